// File: hw/bpm_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef BPM_MAP_SVH
`define BPM_MAP_SVH

`define BPM_OFF_PCTRL 12'h000
`define BPM_OFF_IEN 12'h004
`define BPM_OFF_RSRC 12'h008
`define BPM_OFF_ISTAT 12'h00C
`define BPM_OFF_IMASK 12'h010
`define BPM_OFF_STATE 12'h014

`define BPM_PCTRL_MODE_LSB 0
`define BPM_PCTRL_SEL_BIT 4
`define BPM_PCTRL_PD_BIT 5
`define BPM_IEN_BO_BIT 5
`define BPM_IEN_GLB_BIT 7
`define BPM_RSRC_POF_BIT 4
`define BPM_RSRC_BOF_BIT 5

`define BPM_PCTRL_RESET 8'h00
`define BPM_IEN_RESET 8'h00
`define BPM_IMASK_RESET 3'h0

`define BPM_RST_PULSE_NS 400
`define BPM_CLK_PERIOD_NS 25
`define BPM_RST_PULSE_CYC \
  ((`BPM_RST_PULSE_NS + `BPM_CLK_PERIOD_NS - 1) / `BPM_CLK_PERIOD_NS)

`endif

// File: hw/bpm_pkg.sv
// Types of the brownout and power-on monitor
package bpm_pkg;
  typedef enum logic [1:0] {
    BPM_MODE_NORMAL = 2'h0,
    BPM_MODE_IDLE = 2'h1,
    BPM_MODE_PDOWN = 2'h2,
    BPM_MODE_TOTAL = 2'h3
  } bpm_mode_t;
  typedef enum logic [1:0] {
    BPM_RS_IDLE = 2'h0,
    BPM_RS_HOLD = 2'h1,
    BPM_RS_WAIT = 2'h3
  } bpm_rst_state_t;
  typedef logic [11:0] bpm_addr_t;
  typedef logic [31:0] bpm_data_t;
endpackage : bpm_pkg

// File: hw/bpm_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module bpm_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic q_reg;
  logic q_next;

  always_comb begin
    q_next = q_reg;
    if (s2_reg == s3_reg) begin
      q_next = s3_reg;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_reg <= INIT;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end

  assign dout = q_reg;
endmodule : bpm_sync
`default_nettype wire

// File: hw/bpm_monitor.sv
// Brownout and power-on monitor with APB register slave
//
// How it works
// - Erased enable option disables brownout detection
// - Total power down mode disables detection
// - Power-down bit disables detection, resets zero
// - Select zero: brownout resets and sets flag
// - Select one with enables: interrupt plus flag
// - Missing enable: no reset/interrupt, flag set
// - Brownout flag sticks until software writes zero
// - Power-on detect sets sticky power-on flag
// - Power-on flag cleared only by writing zero
// - Option programmed: power-on also sets brownout flag
// - Two-bit field selects three reduction modes
// - Field codes normal, idle, power down, total
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "bpm_map.svh"
module bpm_monitor (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic BROWNOUT_OPTION_ENABLE,
  input wire logic BROWNOUT_DET,
  input wire logic POWER_ON_DET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire bpm_pkg::bpm_addr_t PADDR,
  input wire bpm_pkg::bpm_data_t PWDATA,
  output bpm_pkg::bpm_data_t PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic BROWNOUT_RESET,
  output logic BROWNOUT_IRQ,
  output logic IRQ,
  output bpm_pkg::bpm_mode_t POWER_MODE
);
  import bpm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic bo_sync;
  logic po_sync;
  logic opt_sync;
  logic bo_prev_reg;
  logic po_prev_reg;

  bpm_sync #(.INIT(1'b0)) u_bo_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .din(BROWNOUT_DET),
    .dout(bo_sync)
  );
  bpm_sync #(.INIT(1'b0)) u_po_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .din(POWER_ON_DET),
    .dout(po_sync)
  );
  bpm_sync #(.INIT(1'b0)) u_opt_sync (
    .clk(CORE_CLK),
    .rst(RESET),
    .din(BROWNOUT_OPTION_ENABLE),
    .dout(opt_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] pctrl_reg;
  logic [7:0] pctrl_next;
  logic [7:0] ien_reg;
  logic [7:0] ien_next;
  logic bof_reg;
  logic bof_next;
  logic pof_reg;
  logic pof_next;
  logic [2:0] istat_reg;
  logic [2:0] istat_next;
  logic [2:0] imask_reg;
  logic [2:0] imask_next;
  bpm_data_t prdata_reg;
  bpm_data_t prdata_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic pready_reg;
  logic pready_next;

  bpm_mode_t mode;
  logic det_enable;
  logic bo_rise;
  logic po_rise;
  logic bo_sel;
  logic irq_ok;
  logic wr_acc;
  logic rd_acc;
  logic addr_hit;

  assign mode = bpm_mode_t'(pctrl_reg[`BPM_PCTRL_MODE_LSB +: 2]);
  always_comb begin
    det_enable = 1'b0;
    if (opt_sync) begin
      unique case (mode)
        BPM_MODE_TOTAL: det_enable = 1'b0;
        BPM_MODE_NORMAL, BPM_MODE_IDLE, BPM_MODE_PDOWN: begin
          det_enable = ~pctrl_reg[`BPM_PCTRL_PD_BIT];
        end
      endcase
    end
  end

  assign bo_rise = bo_sync & ~bo_prev_reg & det_enable;
  assign po_rise = po_sync & ~po_prev_reg;
  assign bo_sel = pctrl_reg[`BPM_PCTRL_SEL_BIT];
  assign irq_ok = ien_reg[`BPM_IEN_BO_BIT] & ien_reg[`BPM_IEN_GLB_BIT];

  assign wr_acc = PSEL & PENABLE & PWRITE & pready_reg;
  assign rd_acc = PSEL & ~PENABLE & ~PWRITE;
  always_comb begin
    unique case (PADDR)
      `BPM_OFF_PCTRL, `BPM_OFF_IEN, `BPM_OFF_RSRC,
      `BPM_OFF_ISTAT, `BPM_OFF_IMASK, `BPM_OFF_STATE: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    pctrl_next = pctrl_reg;
    ien_next = ien_reg;
    bof_next = bof_reg;
    pof_next = pof_reg;
    istat_next = istat_reg;
    imask_next = imask_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = PSEL & ~PENABLE;
    if (wr_acc) begin
      unique case (PADDR)
        `BPM_OFF_PCTRL: pctrl_next = PWDATA[7:0];
        `BPM_OFF_IEN: ien_next = PWDATA[7:0];
        `BPM_OFF_RSRC: begin
          if (!PWDATA[`BPM_RSRC_BOF_BIT]) bof_next = 1'b0;
          if (!PWDATA[`BPM_RSRC_POF_BIT]) pof_next = 1'b0;
        end
        `BPM_OFF_ISTAT: istat_next = istat_reg & ~PWDATA[2:0];
        `BPM_OFF_IMASK: imask_next = PWDATA[2:0];
        default: ;
      endcase
    end
    if (rd_acc) begin
      prdata_next = '0;
      unique case (PADDR)
        `BPM_OFF_PCTRL: prdata_next[7:0] = pctrl_reg;
        `BPM_OFF_IEN: prdata_next[7:0] = ien_reg;
        `BPM_OFF_RSRC: begin
          prdata_next[`BPM_RSRC_BOF_BIT] = bof_reg;
          prdata_next[`BPM_RSRC_POF_BIT] = pof_reg;
        end
        `BPM_OFF_ISTAT: prdata_next[2:0] = istat_reg;
        `BPM_OFF_IMASK: prdata_next[2:0] = imask_reg;
        `BPM_OFF_STATE: prdata_next[3:0] = {opt_sync, det_enable,
                                            po_sync, bo_sync};
        default: ;
      endcase
    end
    if (PSEL & ~PENABLE & ~addr_hit) pslverr_next = 1'b1;
    // Hardware set beats software clear
    if (bo_rise) bof_next = 1'b1;
    if (po_rise) begin
      pof_next = 1'b1;
      if (opt_sync) bof_next = 1'b1;
    end
    if (bo_rise) istat_next[0] = 1'b1;
    if (po_rise) istat_next[1] = 1'b1;
    if (bo_rise & bo_sel & irq_ok) istat_next[2] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Brownout reset pulse and interrupt request
  bpm_rst_state_t rs_reg;
  bpm_rst_state_t rs_next;
  logic [4:0] rs_cnt_reg;
  logic [4:0] rs_cnt_next;
  logic bo_reset_next;
  logic bo_irq_next;
  logic irq_next;
  logic bo_reset_reg;
  logic bo_irq_reg;
  logic irq_reg;

  always_comb begin
    rs_next = rs_reg;
    rs_cnt_next = rs_cnt_reg;
    unique case (rs_reg)
      BPM_RS_IDLE: begin
        if (bo_rise & ~bo_sel) begin
          rs_next = BPM_RS_HOLD;
          rs_cnt_next = 5'(`BPM_RST_PULSE_CYC - 1);
        end
      end
      BPM_RS_HOLD: begin
        if (rs_cnt_reg == 5'h00) rs_next = BPM_RS_WAIT;
        else rs_cnt_next = rs_cnt_reg - 5'h01;
      end
      BPM_RS_WAIT: begin
        if (!bo_sync) rs_next = BPM_RS_IDLE;
      end
      default: rs_next = BPM_RS_IDLE;
    endcase
    bo_reset_next = (rs_next == BPM_RS_HOLD);
    // Interrupt level while brownout persists and routing allows it
    bo_irq_next = det_enable & bo_sync & bo_sel & irq_ok;
    irq_next = |(istat_next & imask_reg);
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pctrl_reg <= `BPM_PCTRL_RESET;
      ien_reg <= `BPM_IEN_RESET;
      bof_reg <= 1'b0;
      pof_reg <= 1'b0;
      istat_reg <= 3'h0;
      imask_reg <= `BPM_IMASK_RESET;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
      bo_prev_reg <= 1'b0;
      po_prev_reg <= 1'b0;
      rs_reg <= BPM_RS_IDLE;
      rs_cnt_reg <= 5'h00;
      bo_reset_reg <= 1'b0;
      bo_irq_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      pctrl_reg <= pctrl_next;
      ien_reg <= ien_next;
      bof_reg <= bof_next;
      pof_reg <= pof_next;
      istat_reg <= istat_next;
      imask_reg <= imask_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      pready_reg <= pready_next;
      bo_prev_reg <= bo_sync;
      po_prev_reg <= po_sync;
      rs_reg <= rs_next;
      rs_cnt_reg <= rs_cnt_next;
      bo_reset_reg <= bo_reset_next;
      bo_irq_reg <= bo_irq_next;
      irq_reg <= irq_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign BROWNOUT_RESET = bo_reset_reg;
  assign BROWNOUT_IRQ = bo_irq_reg;
  assign IRQ = irq_reg;
  assign POWER_MODE = bpm_mode_t'(pctrl_reg[`BPM_PCTRL_MODE_LSB +: 2]);
endmodule : bpm_monitor
`default_nettype wire

// File: tb/bpm_assertions.sv
// Port checker of the brownout and power-on monitor
`timescale 1ns/100ps
`default_nettype none
module bpm_assertions (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic BROWNOUT_OPTION_ENABLE,
  input wire logic BROWNOUT_DET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire bpm_pkg::bpm_addr_t PADDR,
  input wire bpm_pkg::bpm_data_t PWDATA,
  input wire logic PREADY,
  input wire logic BROWNOUT_RESET,
  input wire logic BROWNOUT_IRQ,
  input wire bpm_pkg::bpm_mode_t POWER_MODE
);
  import bpm_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  sequence s_half;
    BROWNOUT_RESET [*8];
  endsequence
  property p_opt_off;
    !BROWNOUT_OPTION_ENABLE [*6] |-> !BROWNOUT_IRQ;
  endproperty
  a_opt_off: assert property (p_opt_off)
    else $error("irq with option erased");
  property p_total_off;
    POWER_MODE == 2'h3 [*2] |-> !BROWNOUT_IRQ;
  endproperty
  a_total_off: assert property (p_total_off)
    else $error("irq in total power down");
  property p_rst_pulse;
    $rose(BROWNOUT_RESET) |-> s_half ##1 s_half ##1 !BROWNOUT_RESET;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pulse width wrong");
  property p_no_rst_irq;
    BROWNOUT_IRQ |-> !$rose(BROWNOUT_RESET);
  endproperty
  a_no_rst_irq: assert property (p_no_rst_irq)
    else $error("reset and interrupt together");
  property p_irq_drop;
    !BROWNOUT_DET [*7] |-> !BROWNOUT_IRQ;
  endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("irq without brownout");
  property p_sync_irq;
    $rose(BROWNOUT_IRQ) |-> $past(BROWNOUT_DET, 3);
  endproperty
  a_sync_irq: assert property (p_sync_irq)
    else $error("irq rose too early");
  property p_sync_rst;
    $rose(BROWNOUT_RESET) |-> $past(BROWNOUT_DET, 3);
  endproperty
  a_sync_rst: assert property (p_sync_rst)
    else $error("reset rose too early");
  property p_mode_wr;
    PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000
      |=> POWER_MODE == $past(PWDATA[1:0]);
  endproperty
  a_mode_wr: assert property (p_mode_wr)
    else $error("mode output wrong");
endmodule : bpm_assertions
////////////////////////////////////////////////////////////////////////////
bind bpm_monitor bpm_assertions i_chk (.CORE_CLK, .RESET,
  .BROWNOUT_OPTION_ENABLE, .BROWNOUT_DET, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PREADY, .BROWNOUT_RESET, .BROWNOUT_IRQ, .POWER_MODE);
`default_nettype wire

// File: tb/brownout_poweron_monitor_tb_top.sv
// Self-checking bench of the brownout and power-on monitor
`timescale 1ns/100ps
`default_nettype none
module brownout_poweron_monitor_tb_top;
  import bpm_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RESET = 1'b1;
  logic BROWNOUT_OPTION_ENABLE = 1'b1;
  logic BROWNOUT_DET = 1'b0;
  logic POWER_ON_DET = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  bpm_addr_t PADDR = 12'h000;
  bpm_data_t PWDATA = 32'h0;
  bpm_data_t PRDATA;
  logic PREADY, PSLVERR, BROWNOUT_RESET, BROWNOUT_IRQ, IRQ;
  bpm_mode_t POWER_MODE;
  logic [32:0] exp_q[$];
  int err_total = 0;
  int check_count = 0;
  integer seed = 43;
  int n;
  int rc;
  always #12.5 CORE_CLK = ~CORE_CLK;
  bpm_monitor i_dut (.CORE_CLK, .RESET, .BROWNOUT_OPTION_ENABLE,
    .BROWNOUT_DET, .POWER_ON_DET, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .BROWNOUT_RESET, .BROWNOUT_IRQ,
    .IRQ, .POWER_MODE);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cyc(input int k);
    repeat (k) @(posedge CORE_CLK);
  endtask : cyc
  // One APB transfer; reads note {PSLVERR, PRDATA} expected
  task automatic apb(input logic wr, input bpm_addr_t a, input bpm_data_t d,
      input logic [32:0] e);
    if (!wr) exp_q.push_back(e);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      wrap_up;
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask : apb
  always @(posedge CORE_CLK) begin
    if (PSEL && PENABLE && PREADY && !PWRITE)
      chk({PSLVERR, PRDATA}, exp_q.pop_front());
  end
  // Brownout under one setting: irq level, reset cycles, flags
  task automatic run_case(input logic o, input logic [7:0] pc,
      input logic [7:0] ie, input logic ei, input int er,
      input logic [32:0] eb);
    BROWNOUT_OPTION_ENABLE <= o;
    apb(1'b1, 12'h000, {24'h0, pc}, 33'h0);
    apb(1'b1, 12'h004, {24'h0, ie}, 33'h0);
    apb(1'b1, 12'h008, 32'h0, 33'h0);
    cyc(8);
    BROWNOUT_DET <= 1'b1;
    rc = 0;
    repeat (40) begin
      @(posedge CORE_CLK);
      rc += (BROWNOUT_RESET === 1'b1);
    end
    chk(BROWNOUT_IRQ, ei);
    chk(rc, er);
    BROWNOUT_DET <= 1'b0;
    cyc(10);
    apb(1'b0, 12'h008, 32'h0, eb);
    $display("case pc=%h ie=%h done", pc, ie);
  endtask : run_case
  ////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(6);
    RESET <= 1'b0;
    cyc(2);
    apb(1'b0, 12'h000, 32'h0, 33'h0);
    POWER_ON_DET <= 1'b1;
    cyc(10);
    POWER_ON_DET <= 1'b0;
    cyc(6);
    apb(1'b0, 12'h008, 32'h0, 33'h30);
    chk(IRQ, 1'b0);
    apb(1'b1, 12'h010, 32'h2, 33'h0);
    cyc(2);
    chk(IRQ, 1'b1);
    apb(1'b1, 12'h00C, 32'h7, 33'h0);
    cyc(2);
    chk(IRQ, 1'b0);
    apb(1'b1, 12'h010, 32'h0, 33'h0);
    apb(1'b1, 12'h008, 32'h30, 33'h0);
    apb(1'b0, 12'h008, 32'h0, 33'h30);
    apb(1'b1, 12'h008, 32'h0, 33'h0);
    apb(1'b0, 12'h008, 32'h0, 33'h0);
    apb(1'b1, 12'h020, 32'hF, 33'h0);
    apb(1'b0, 12'h020, 32'h0, 33'h1_0000_0000);
    $display("flags and interrupt test done");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h000, ($random(seed) & 32'h10) | m, 33'h0);
      chk(POWER_MODE, m);
    end
    $display("mode test done");
    run_case(1'b0, 8'h10, 8'hA0, 1'b0, 0, 33'h0);
    run_case(1'b1, 8'h13, 8'hA0, 1'b0, 0, 33'h0);
    run_case(1'b1, 8'h30, 8'hA0, 1'b0, 0, 33'h0);
    run_case(1'b1, 8'h10, 8'hA0, 1'b1, 0, 33'h20);
    run_case(1'b1, 8'h11, 8'hA0, 1'b1, 0, 33'h20);
    run_case(1'b1, 8'h12, 8'hA0, 1'b1, 0, 33'h20);
    run_case(1'b1, 8'h10, 8'h20, 1'b0, 0, 33'h20);
    run_case(1'b1, 8'h10, 8'h80, 1'b0, 0, 33'h20);
    run_case(1'b1, 8'h00, 8'hA0, 1'b0, 16, 33'h20);
    wrap_up;
  end
endmodule : brownout_poweron_monitor_tb_top
`default_nettype wire
